// File: hdl/event_latch.sv
// Sticky event latch, eight bits, set beats clear
`timescale 1ns/1ps
`include "std_event_params.svh"
module event_latch (
  input  wire logic   clk,
  input  wire logic   rst_n,
  event_set_if.lat    ev
);
  import std_event_pkg::*;
  event_byte_t latch_q;
  event_byte_t next_latch;

  // Set dominates clear so no event is dropped on a clearing read
  always_comb begin
    next_latch = latch_q;
    if (ev.clear) begin
      next_latch = `EVT_RESET;
    end
    next_latch = next_latch | ev.set_bits;
    next_latch[`BIT_USER_REQ] = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= `EVT_RESET;
    end else begin
      latch_q <= next_latch;
    end
  end

  assign ev.latched = latch_q;

  AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
    (ev.set_bits[`BIT_CMD_ERR]) |=> latch_q[`BIT_CMD_ERR])
    else $error("command error event lost");
  AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (!ev.clear && latch_q[`BIT_EXE_ERR]) |=> latch_q[`BIT_EXE_ERR])
    else $error("latched bit dropped without clear");
  AST_USER_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    latch_q[`BIT_USER_REQ] == 1'b0)
    else $error("user request bit set");
endmodule

// File: hdl/event_set_if.sv
// Interface carrying event sources into the latch
`timescale 1ns/1ps
interface event_set_if;
  logic [7:0] set_bits;
  logic       clear;
  logic [7:0] latched;
  modport src (output set_bits, output clear, input latched);
  modport lat (input set_bits, input clear, output latched);
endinterface

// File: hdl/standard_event_status_reg.sv
// Standard event status register with query answer and enable mask
`timescale 1ns/1ps
`include "std_event_params.svh"
module standard_event_status_reg (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      power_cycled,
  input  wire logic                      cmd_error,
  input  wire logic                      exec_error,
  input  wire logic                      dev_error,
  input  wire logic                      query_error,
  input  wire logic                      req_control,
  input  wire logic                      opc_armed,
  input  wire logic                      ops_done,
  input  wire logic                      esr_query,
  input  wire logic                      clear_status,
  input  wire logic                      mask_write,
  input  wire std_event_pkg::event_byte_t mask_wdata,
  input  wire logic                      mask_query,
  output logic                           answer_valid,
  output std_event_pkg::event_byte_t     answer_data,
  output std_event_pkg::event_word_t     event_word,
  output std_event_pkg::event_byte_t     enable_mask,
  output logic                           summary_bit
);
  import std_event_pkg::*;

  logic          rst_meta;
  logic          rst_sync;
  event_byte_t   next_mask;
  event_byte_t   ans_data_q;
  event_byte_t   next_ans_data;
  logic          ans_valid_q;
  logic          next_ans_valid;
  logic          opc_pending;
  logic          next_opc_pending;
  event_byte_t   sets;
  event_byte_t   mask_q;
  event_set_if   ev ();

  // Commands that expect a value back in the output queue
  function automatic logic wants_answer(input logic evt_q, input logic msk_q);
    return evt_q || msk_q;
  endfunction

  // Commands that wipe the event bits; set still wins in the latch
  function automatic logic clears_events(input logic evt_q, input logic cls);
    return evt_q || cls;
  endfunction

  // Reset release through two flops; assert is async
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Operation complete waits for an armed opc and finished operations
  always_comb begin
    next_opc_pending = opc_pending;
    if (opc_armed) begin
      next_opc_pending = 1'b1;
    end else if (opc_pending && ops_done) begin
      next_opc_pending = 1'b0;
    end
  end

  // Event sources mapped to their bit weights
  always_comb begin
    sets = `EVT_RESET;
    sets[`BIT_POWER_ON] = power_cycled;
    sets[`BIT_USER_REQ] = 1'b0;
    sets[`BIT_CMD_ERR]  = cmd_error;
    sets[`BIT_EXE_ERR]  = exec_error;
    sets[`BIT_DEV_ERR]  = dev_error;
    sets[`BIT_QRY_ERR]  = query_error;
    sets[`BIT_REQ_CTL]  = req_control;
    sets[`BIT_OP_DONE]  = opc_pending && ops_done && !opc_armed;
  end

  // Latch inputs: a read and a clear-status wipe alike
  assign ev.set_bits = sets;
  assign ev.clear    = clears_events(esr_query, clear_status);

  // Sticky bits sit apart so set-wins logic can be checked on its own
  event_latch u_latch (
    .clk   (sys_clk),
    .rst_n (rst_sync),
    .ev    (ev)
  );

  // Answer path: snapshot taken before the clear lands
  always_comb begin
    next_ans_valid = 1'b0;
    next_ans_data  = ans_data_q;
    if (esr_query) begin
      next_ans_valid = 1'b1;
      next_ans_data  = ev.latched;
    end else if (mask_query) begin
      next_ans_valid = 1'b1;
      next_ans_data  = mask_q;
    end
  end

  // Mask write; query of mask has no side effect
  always_comb begin
    next_mask = mask_q;
    if (mask_write) begin
      next_mask = mask_wdata;
    end
  end

  // State registers; synchronised reset keeps release off the raw pin
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      mask_q      <= `MASK_RESET;
      ans_data_q  <= `EVT_RESET;
      ans_valid_q <= 1'b0;
      opc_pending <= 1'b0;
    end else begin
      mask_q      <= next_mask;
      ans_data_q  <= next_ans_data;
      ans_valid_q <= next_ans_valid;
      opc_pending <= next_opc_pending;
    end
  end

  // Outputs; the summary is combinational so it tracks the latch at once
  assign answer_valid = ans_valid_q;
  assign answer_data  = ans_data_q;
  assign event_word   = {`RESERVED_HI, ev.latched};
  assign enable_mask  = mask_q;
  assign summary_bit  = |(ev.latched & mask_q);

  // Checks on the register, from its ports and from the latch and source signals inside it
  AST_RESERVED_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    event_word[`EVT_REG_W-1:`EVT_LIVE_W] == `RESERVED_HI)
    else $error("reserved bits nonzero");
  AST_QUERY_ANSWER: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    esr_query |=> (answer_valid && answer_data == $past(ev.latched)))
    else $error("query answer wrong");
  AST_QUERY_CLEARS: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    (esr_query && sets == 8'h00) |=> ev.latched == 8'h00)
    else $error("query did not clear");
  AST_CLS_CLEARS: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    (clear_status && sets == 8'h00) |=> ev.latched == 8'h00)
    else $error("clear status did not clear");
  AST_SUMMARY: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    summary_bit == ((ev.latched & mask_q) != 8'h00))
    else $error("summary mismatch");
  AST_POWER: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    power_cycled |=> ev.latched[`BIT_POWER_ON])
    else $error("power on not latched");
  AST_OPC_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    (!$past(opc_pending) && !$past(ev.clear) && !$past(ev.latched[`BIT_OP_DONE]))
    |-> !ev.latched[`BIT_OP_DONE])
    else $error("opc bit without opc");
  AST_MASK: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    mask_write |=> enable_mask == $past(mask_wdata))
    else $error("mask not written");

  // Each error source and the control request reach their latch bits one cycle later
  AST_CMD: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    cmd_error |=> ev.latched[`BIT_CMD_ERR])
    else $error("command error not latched");
  AST_EXEC: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    exec_error |=> ev.latched[`BIT_EXE_ERR])
    else $error("execution error not latched");
  AST_DEV: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    dev_error |=> ev.latched[`BIT_DEV_ERR])
    else $error("device error not latched");
  AST_QUERY_ERR: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    query_error |=> ev.latched[`BIT_QRY_ERR])
    else $error("query error not latched");
  AST_REQ_CTL: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    req_control |=> ev.latched[`BIT_REQ_CTL])
    else $error("control request not latched");

  // Op complete needs an armed request, finished work and no new arm in that same cycle
  AST_OPC_SETS: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    (opc_pending && ops_done && !opc_armed) |=> ev.latched[`BIT_OP_DONE])
    else $error("op complete not latched");
  AST_OPC_NEEDS_DONE: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    (!ops_done && !ev.latched[`BIT_OP_DONE]) |=> !ev.latched[`BIT_OP_DONE])
    else $error("op complete set while work pending");

  // Answer strobe lasts one cycle; data must not drift between queries
  AST_ANSWER_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    !wants_answer(esr_query, mask_query) |=> !answer_valid)
    else $error("answer without a query");
  AST_ANSWER_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    !wants_answer(esr_query, mask_query) |=> $stable(answer_data))
    else $error("answer data moved without a query");
  AST_MASK_ANSWER: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    (mask_query && !esr_query) |=> (answer_valid && answer_data == $past(enable_mask)))
    else $error("mask answer wrong");

  // Mask changes only on a write; a clearing query drops the summary
  AST_MASK_STABLE: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    !mask_write |=> $stable(enable_mask))
    else $error("mask changed without a write");
  AST_SUMMARY_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    (esr_query && sets == `EVT_RESET) |=> !summary_bit)
    else $error("summary left set after query");

  // Per bit: only a clear takes a bit down, only its source puts it up
  for (genvar b = 0; b < `EVT_LIVE_W; b++) begin : g_bit_check
    AST_BIT_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_sync)
      (ev.latched[b] && !ev.clear) |=> ev.latched[b])
      else $error("event bit dropped without a clear");
    AST_BIT_NO_SPUR: assert property (@(posedge sys_clk) disable iff (!rst_sync)
      (!ev.latched[b] && !ev.set_bits[b]) |=> !ev.latched[b])
      else $error("event bit set without its source");
  end

  // Scenarios worth seeing: reads, races with a clear, op complete
  COV_QUERY: cover property (@(posedge sys_clk) esr_query && ev.latched != 8'h00);
  COV_SUMMARY: cover property (@(posedge sys_clk) $rose(summary_bit));
  COV_RACE: cover property (@(posedge sys_clk) esr_query && cmd_error);
  COV_CLS_RACE: cover property (@(posedge sys_clk) clear_status && ev.set_bits != `EVT_RESET);
  COV_OPC: cover property (@(posedge sys_clk) $rose(ev.latched[`BIT_OP_DONE]));
endmodule

// File: hdl/std_event_params.svh
// Constants for the standard event status block
// Notes on behaviour
// - Bits 15 to 8 of the event register always read zero.
// - Bit 7 latches when supply cycled off and on since last read.
// - Bit 6, user request, is never set.
// - Bit 5 latches on any command processing error.
// - Bit 4 latches on any execution error.
// - Bit 3 latches on device dependent error, e.g. overrange.
// - Bit 2 latches on query error: empty read or lost output data.
// - Bit 1 latches while requesting to become active controller.
// - Bit 0 latches only on operation complete after an opc command.
// - Event query returns register value, 0 to 255, to output queue.
// - Answering the event query clears every event bit; a bit whose source fires in the query cycle stays set.
// - Eight bit enable mask; OR of enabled set bits is status bit 5.
// - Clear status command also clears the event register; a bit whose source fires in the same cycle stays set.
`ifndef STD_EVENT_PARAMS_SVH
`define STD_EVENT_PARAMS_SVH
`define EVT_REG_W      16
`define EVT_LIVE_W     8
`define BIT_POWER_ON   7
`define BIT_USER_REQ   6
`define BIT_CMD_ERR    5
`define BIT_EXE_ERR    4
`define BIT_DEV_ERR    3
`define BIT_QRY_ERR    2
`define BIT_REQ_CTL    1
`define BIT_OP_DONE    0
`define EVT_RESET      8'h00
`define MASK_RESET     8'h00
`define RESERVED_HI    8'h00
`endif

// File: hdl/std_event_pkg.sv
// Types shared by the standard event status block
package std_event_pkg;
  typedef logic [7:0] event_byte_t;
  typedef logic [15:0] event_word_t;
  typedef enum logic [1:0] {
    ANS_IDLE = 2'b00,
    ANS_SEND = 2'b01
  } answer_state_t;
endpackage

// File: tb/ctl_model.sv
// Bus controller model issuing common commands and reading answers
`timescale 1ns/1ps
module ctl_model (
  input  wire logic                       sys_clk,
  input  wire logic                       answer_valid,
  input  wire std_event_pkg::event_byte_t answer_data,
  output logic                            esr_query,
  output logic                            clear_status,
  output logic                            mask_write,
  output std_event_pkg::event_byte_t      mask_wdata,
  output logic                            mask_query
);
  import std_event_pkg::*;
  // Idle: no command, data line not left at a stale value
  initial begin
    {esr_query, clear_status, mask_write, mask_query} = 4'h0;
    mask_wdata = 8'h5a;
  end
  // Command held one cycle; the one-cycle answer is read mid-cycle after it
  task automatic cmd(input logic [3:0] op, input event_byte_t val,
                     output event_byte_t ans, output logic ok);
    @(negedge sys_clk);
    {esr_query, clear_status, mask_write, mask_query} = op;
    mask_wdata = val;
    @(negedge sys_clk);
    ok = answer_valid;
    ans = answer_data;
    {esr_query, clear_status, mask_write, mask_query} = 4'h0;
    mask_wdata = ~val; // Released data inverts so stale values never match
  endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the standard event status register
`timescale 1ns/1ps
module tb;
  import std_event_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  src = 6'h00;
  logic        opc_armed = 1'b0;
  logic        ops_done = 1'b0;
  logic        esr_query, clear_status, mask_write, mask_query, answer_valid, summary_bit, ok;
  event_byte_t mask_wdata, answer_data, enable_mask, ans;
  event_word_t event_word;
  int          mismatches = 0, check_count = 0, cycles = 0;
  // Rows: sources {power, cmd, exec, dev, query, reqctl} and expected byte
  logic [5:0]  row_src [7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h3f};
  event_byte_t row_exp [7] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'hbe};
  always #4 sys_clk = ~sys_clk;
  standard_event_status_reg uut (.sys_clk(sys_clk), .rst_n(rst_n), .power_cycled(src[5]),
    .cmd_error(src[4]), .exec_error(src[3]), .dev_error(src[2]), .query_error(src[1]),
    .req_control(src[0]), .opc_armed(opc_armed), .ops_done(ops_done), .esr_query(esr_query),
    .clear_status(clear_status), .mask_write(mask_write), .mask_wdata(mask_wdata),
    .mask_query(mask_query), .answer_valid(answer_valid), .answer_data(answer_data),
    .event_word(event_word), .enable_mask(enable_mask), .summary_bit(summary_bit));
  ctl_model ctl (.sys_clk(sys_clk), .answer_valid(answer_valid), .answer_data(answer_data),
    .esr_query(esr_query), .clear_status(clear_status), .mask_write(mask_write),
    .mask_wdata(mask_wdata), .mask_query(mask_query));
  // Compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One-cycle event pulse, launched on the falling edge
  task automatic pulse(input logic [5:0] s);
    @(negedge sys_clk);
    src = s;
    @(negedge sys_clk);
    src = 6'h00;
  endtask
  // Cycle ceiling; the whole run needs about 60 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    chk("reset word", event_word, 16'h0000);
    chk("reset valid", {15'h0, answer_valid}, 16'h0000);
    $display("test reset done");
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    ctl.cmd(4'h2, 8'hff, ans, ok);
    for (int i = 0; i < 7; i++) begin
      pulse(row_src[i]);
      chk("word", event_word, {8'h00, row_exp[i]});
      chk("summary", {15'h0, summary_bit}, 16'h0001);
      ctl.cmd(4'h8, 8'h00, ans, ok);
      chk("answer", {7'h0, ok, ans}, {8'h01, row_exp[i]});
      chk("cleared", event_word, 16'h0000);
    end
    $display("test rows done");
    ctl.cmd(4'h2, 8'h24, ans, ok);
    ctl.cmd(4'h1, 8'h00, ans, ok);
    chk("mask", {7'h0, ok, ans}, 16'h0124);
    chk("enable", {8'h00, enable_mask}, 16'h0024);
    pulse(6'h08);
    chk("masked off", {15'h0, summary_bit}, 16'h0000);
    pulse(6'h10);
    chk("masked on", {15'h0, summary_bit}, 16'h0001);
    // Clear with an event in the same cycle: the new event survives
    fork
      ctl.cmd(4'h4, 8'h00, ans, ok);
      pulse(6'h04);
    join
    chk("clear", event_word, 16'h0008);
    $display("test mask and clear done");
    ctl.cmd(4'h8, 8'h00, ans, ok);
    chk("race answer", {7'h0, ok, ans}, 16'h0108);
    @(negedge sys_clk);
    ops_done = 1'b1;
    @(negedge sys_clk);
    chk("no opc", event_word, 16'h0000);
    opc_armed = 1'b1;
    @(negedge sys_clk);
    opc_armed = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("opc", event_word, 16'h0001);
    ctl.cmd(4'h9, 8'h00, ans, ok);
    chk("priority", {7'h0, ok, ans}, 16'h0101);
    chk("priority clear", event_word, 16'h0000);
    $display("test opc done");
    final_report();
  end
endmodule
